//--- design/servo_fault_encoder_history.v
// Fault supervisor of a servo drive: detection, alarm outputs, power-stage
// gating, ten-entry alarm history, APB register access.
// Assumes every input is synchronous to pclk and presetn is the power-up reset.
`timescale 1ns/1ps
`include "fault_map.vh"

// Functional notes
// - Any detected fault raises flag, code, power-stage off and display id.
// - Alarm flag output is low while an alarm is present.
// - Overcurrent drives code 3'b001.
// - Regeneration fault drives code 3'b011.
// - Deviation count above the set limit raises code 3'b011.
// - Bus voltage outside 150..420 V raises code 3'b100.
// - Speed at or above 4950 rpm raises code 3'b101.
// - Overload, inverse time, two ids by load band, code 3'b111.
// - Heatsink overheating raises code 3'b111.
// - Converter done missing within the timeout raises code 3'b000.
// - Runaway and encoder wiring faults get distinct ids, code 3'b101.
// - Supply phase loss raises code 3'b010.
// - Parameter checksum mismatch raises code 3'b000.
// - Bad absolute data on sense request raises code 3'b000 on absolute models.
// - Reset marker is logged and also shown on the display while idle: flag inactive, code zero.
// - Operator unit link failures are displayed but never logged.
// - Alarm clears by clear input, power-up or operator unit reset command.
// - Power-up alone does not clear an overcurrent alarm.
// - With run enabled the power stage resumes as soon as the alarm clears.
// - The ten most recent identifiers are kept.
// - A reset marker is logged on every alarm clear and on a power-up with no fault raised in the first cycle.
// - Higher history index means older entry.
// - Selector value 02 plus set key erases the history.
module servo_fault_encoder_history #(
    parameter DEV_W    = 16,
    parameter OL_LIMIT = 32'd600000000
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    // Fault detectors
    input  wire        oc_detect,
    input  wire        regen_fault,
    input  wire [DEV_W-1:0] dev_residual,
    input  wire [9:0]  bus_volts,
    input  wire [12:0] speed_rpm,
    input  wire [7:0]  load_pct,
    input  wire        heatsink_hot,
    input  wire        adc_start,
    input  wire        adc_done,
    input  wire        enc_runaway,
    input  wire        enc_phase_err,
    input  wire        enc_ab_fault,
    input  wire        enc_z_fault,
    input  wire        phase_loss,
    input  wire        param_csum_bad,
    input  wire        abs_model,
    input  wire        position_sense_request,
    input  wire        abs_data_bad,
    input  wire        opu_tx_fail_pwrup,
    input  wire        opu_tx_timeout,
    input  wire        oc_hold_in,
    // Host control
    input  wire        alarm_clear,
    input  wire        run_enable,
    // Alarm outputs
    output reg         fault_flag_out,
    output reg         fault_code_bit0,
    output reg         fault_code_bit1,
    output reg         fault_code_bit2,
    output wire        power_stage_on,
    output reg  [7:0]  display_id,
    output reg  [1:0]  display_comm,
    output wire        oc_hold_out
);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Alarm code for an identifier; unknown ids and the marker give zero
    function [2:0] code_of;
        input [7:0] id;
        begin
            case (id)
                `ID_OVERCURRENT : code_of = 3'b001;
                `ID_REGEN,
                `ID_DEVIATION   : code_of = 3'b011;
                `ID_VOLTAGE     : code_of = 3'b100;
                `ID_OVERSPEED,
                `ID_RUNAWAY,
                `ID_ENC_PHASE,
                `ID_ENC_AB,
                `ID_ENC_Z       : code_of = 3'b101;
                `ID_OVERLOAD_HI,
                `ID_OVERLOAD_LO,
                `ID_HEATSINK    : code_of = 3'b111;
                `ID_PHASE_LOSS  : code_of = 3'b010;
                default         : code_of = 3'b000;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    localparam HW = 4;
    localparam [HW-1:0] HMAX = `HIST_DEPTH;
    localparam [31:0] ADC_CYC = `ADC_TIMEOUT_CYC;

    reg  [7:0]       selector_r;
    reg  [DEV_W-1:0] devlim_r;
    reg  [15:0]      setup_r;
    reg  [HW-1:0]    hsel_r;
    reg              alarm_r;
    reg  [7:0]       alarm_id_r;
    reg  [7:0]       hist_r [0:`HIST_DEPTH-1];
    reg  [HW-1:0]    hcount_r;
    reg              boot_r;
    reg  [31:0]      ol_acc_r;
    reg              adc_busy_r;
    reg  [31:0]      adc_cnt_r;
    reg              adc_late_r;
    integer          i;

    // APB strobes
    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire mapped = (paddr == `REG_CTRL)   | (paddr == `REG_DEVLIM) |
                  (paddr == `REG_STATUS) | (paddr == `REG_SETUP)  |
                  (paddr == `REG_HSEL)   | (paddr == `REG_HDATA);
    wire ctrl_wr = wr_en & (paddr == `REG_CTRL);
    wire opu_reset = ctrl_wr & pwdata[`CTRL_OPU_RESET_BIT];
    wire set_key = ctrl_wr & pwdata[`CTRL_SET_KEY_BIT];
    wire erase = set_key & (selector_r == `SEL_ERASE_HISTORY);

    assign pready = 1'b1;

    // ---------------------------------------------------------------
    // Detection
    // ---------------------------------------------------------------
    // Overload thermal model: excess load integrates, so higher load trips
    // sooner; below rating the model cools slowly.
    wire [7:0] excess = (load_pct > `LOAD_RATED_PCT) ?
                        (load_pct - `LOAD_RATED_PCT) : 8'h00;
    wire       ol_trip = (ol_acc_r >= OL_LIMIT) & (load_pct > `LOAD_LOW_PCT);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ol_acc_r <= 32'h0000_0000;
        else if (excess != 8'h00)
        begin
            if (ol_acc_r < OL_LIMIT)
                ol_acc_r <= ol_acc_r + {24'h000000, excess};
        end
        else if (ol_acc_r != 32'h0000_0000)
            ol_acc_r <= ol_acc_r - 32'h0000_0001;
    end

    // Converter watchdog: a start opens a window that done must close
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_busy_r <= 1'b0;
            adc_cnt_r  <= 32'h0000_0000;
            adc_late_r <= 1'b0;
        end
        else
        begin
            adc_late_r <= 1'b0;
            if (adc_done)
                adc_busy_r <= 1'b0;
            else if (adc_start)
            begin
                adc_busy_r <= 1'b1;
                adc_cnt_r  <= 32'h0000_0000;
            end
            else if (adc_busy_r)
            begin
                if (adc_cnt_r >= ADC_CYC - 32'h0000_0001)
                begin
                    adc_busy_r <= 1'b0;
                    adc_late_r <= 1'b1;
                end
                else
                    adc_cnt_r <= adc_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Fixed priority among simultaneous faults; the first listed wins
    reg       det_v;
    reg [7:0] det_id;
    always @*
    begin
        det_v  = 1'b1;
        det_id = 8'h00;
        if (oc_detect)
            det_id = `ID_OVERCURRENT;
        else if (regen_fault)
            det_id = `ID_REGEN;
        else if (dev_residual > devlim_r)
            det_id = `ID_DEVIATION;
        else if ((bus_volts < `BUS_MIN_V) || (bus_volts > `BUS_MAX_V))
            det_id = `ID_VOLTAGE;
        else if (speed_rpm >= `OVERSPEED_RPM)
            det_id = `ID_OVERSPEED;
        else if (ol_trip)
            det_id = (load_pct > `LOAD_HIGH_PCT) ?
                     `ID_OVERLOAD_HI : `ID_OVERLOAD_LO;
        else if (heatsink_hot)
            det_id = `ID_HEATSINK;
        else if (adc_late_r)
            det_id = `ID_ADC_TIMEOUT;
        else if (enc_runaway)
            det_id = `ID_RUNAWAY;
        else if (enc_phase_err)
            det_id = `ID_ENC_PHASE;
        else if (enc_ab_fault)
            det_id = `ID_ENC_AB;
        else if (enc_z_fault)
            det_id = `ID_ENC_Z;
        else if (phase_loss)
            det_id = `ID_PHASE_LOSS;
        else if (param_csum_bad)
            det_id = `ID_PARAM_CSUM;
        else if (abs_model & position_sense_request & abs_data_bad)
            det_id = `ID_ABS_DATA;
        else
            det_v = 1'b0;
    end

    // ---------------------------------------------------------------
    // Alarm state
    // ---------------------------------------------------------------
    // A clear and a fresh detection in one cycle: the detection wins, so a
    // fault still present is never masked by a clear.
    wire clear_req = alarm_clear | opu_reset;
    // Overcurrent survives power-up through the retained level
    wire oc_boot = boot_r & oc_hold_in;
    wire raise = (~alarm_r | clear_req) & (det_v | oc_boot);
    wire [7:0] raise_id = oc_boot ? `ID_OVERCURRENT : det_id;
    wire do_clear = alarm_r & clear_req & ~raise;
    // Power-up marker, or marker on clear; the raise shares the push slot
    wire push = raise | do_clear | (boot_r & ~oc_boot);
    wire [7:0] push_id = raise ? raise_id : `ID_RESET_MARK;
    wire [2:0] raise_code = code_of(raise_id);
    wire [2:0] held_code  = code_of(alarm_id_r);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_r     <= 1'b1;
            alarm_r    <= 1'b0;
            alarm_id_r <= `ID_RESET_MARK;
        end
        else
        begin
            boot_r <= 1'b0;
            if (raise)
            begin
                alarm_r    <= 1'b1;
                alarm_id_r <= raise_id;
            end
            else if (do_clear)
            begin
                alarm_r    <= 1'b0;
                alarm_id_r <= `ID_RESET_MARK;
            end
        end
    end

    // Registered alarm outputs; code follows the id of the latched alarm
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_flag_out  <= 1'b1;
            fault_code_bit0 <= 1'b0;
            fault_code_bit1 <= 1'b0;
            fault_code_bit2 <= 1'b0;
            display_id      <= `ID_RESET_MARK;
            display_comm    <= 2'b00;
        end
        else
        begin
            fault_flag_out  <= ~(raise | (alarm_r & ~do_clear));
            fault_code_bit0 <= raise ? raise_code[0] : (~do_clear & held_code[0]);
            fault_code_bit1 <= raise ? raise_code[1] : (~do_clear & held_code[1]);
            fault_code_bit2 <= raise ? raise_code[2] : (~do_clear & held_code[2]);
            display_id      <= raise ? raise_id :
                               (do_clear ? `ID_RESET_MARK : alarm_id_r);
            display_comm    <= {opu_tx_timeout, opu_tx_fail_pwrup};
        end
    end

    // Power stage off under alarm; resumes at once when it clears
    assign power_stage_on = ~alarm_r & (run_enable |
                            setup_r[`SETUP_ALWAYS_ON_BIT]);
    assign oc_hold_out = alarm_r & (alarm_id_r == `ID_OVERCURRENT);

    // ---------------------------------------------------------------
    // History store
    // ---------------------------------------------------------------
    // Index 0 is newest; a push shifts everything one older and the
    // tenth entry falls off the end. Link failures never reach here.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hcount_r <= {HW{1'b0}};
            for (i = 0; i < `HIST_DEPTH; i = i + 1)
                hist_r[i] <= 8'h00;
        end
        else if (erase)
        begin
            hcount_r <= {HW{1'b0}};
            for (i = 0; i < `HIST_DEPTH; i = i + 1)
                hist_r[i] <= 8'h00;
        end
        else if (push)
        begin
            for (i = `HIST_DEPTH - 1; i > 0; i = i - 1)
                hist_r[i] <= hist_r[i-1];
            hist_r[0] <= push_id;
            if (hcount_r < HMAX)
                hcount_r <= hcount_r + {{(HW-1){1'b0}}, 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // APB writes
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            selector_r <= 8'h00;
            devlim_r   <= `DEVLIM_RESET;
            setup_r    <= `SETUP_RESET;
            hsel_r     <= {HW{1'b0}};
        end
        else if (wr_en)
        begin
            case (paddr)
                `REG_CTRL   : selector_r <= pwdata[`CTRL_SEL_LSB +: 8];
                `REG_DEVLIM : devlim_r   <= pwdata[DEV_W-1:0];
                `REG_SETUP  : setup_r    <= pwdata[15:0];
                `REG_HSEL   : hsel_r     <= pwdata[HW-1:0];
                default     : hsel_r     <= hsel_r;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // APB reads
    // ---------------------------------------------------------------
    // Slots beyond the filled depth read as zero rather than stale data
    wire [7:0] hsel_data = (hsel_r < hcount_r) ? hist_r[hsel_r] : 8'h00;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel & ~penable)
            begin
                pslverr <= ~mapped;
                if (~pwrite)
                begin
                    case (paddr)
                        `REG_CTRL   : prdata <= {16'h0000, selector_r, 8'h00};
                        `REG_DEVLIM : prdata <= {{(32-DEV_W){1'b0}}, devlim_r};
                        `REG_STATUS : prdata <= {12'h000, hcount_r, 2'b00,
                                                 display_comm, fault_code_bit2,
                                                 fault_code_bit1, fault_code_bit0,
                                                 alarm_r, alarm_id_r};
                        `REG_SETUP  : prdata <= {16'h0000, setup_r};
                        `REG_HSEL   : prdata <= {28'h0000000, hsel_r};
                        `REG_HDATA  : prdata <= {24'h000000, hsel_data};
                        default     : prdata <= 32'h0000_0000;
                    endcase
                end
            end
            else if (rd_en)
                prdata <= prdata;
        end
    end

endmodule // servo_fault_encoder_history

//--- design/fault_map.vh
// Register offsets, field positions, alarm identifiers and timing figures
// for the servo fault supervisor.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
`ifndef FAULT_MAP_VH
`define FAULT_MAP_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_MHZ              200
`define ADC_TIMEOUT_NS       10000
`define ADC_TIMEOUT_CYC      ((`ADC_TIMEOUT_NS * `CLK_MHZ) / 1000)

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL             8'h00
`define REG_DEVLIM           8'h04
`define REG_STATUS           8'h08
`define REG_SETUP            8'h0c
`define REG_HSEL             8'h10
`define REG_HDATA            8'h14

// Control register fields
`define CTRL_OPU_RESET_BIT   0
`define CTRL_SET_KEY_BIT     1
`define CTRL_SEL_LSB         8
`define SEL_ERASE_HISTORY    8'h02
`define SETUP_ALWAYS_ON_BIT  0

// Reset values
`define DEVLIM_RESET         16'h0400
`define SETUP_RESET          16'h0000

// ---------------------------------------------------------------
// Detection thresholds
// ---------------------------------------------------------------
`define BUS_MIN_V            10'd150
`define BUS_MAX_V            10'd420
`define OVERSPEED_RPM        13'd4950
`define LOAD_RATED_PCT       8'd100
`define LOAD_LOW_PCT         8'd120
`define LOAD_HIGH_PCT        8'd135

// ---------------------------------------------------------------
// Alarm identifiers as shown on the display
// ---------------------------------------------------------------
`define ID_ABS_DATA          8'h00
`define ID_PARAM_CSUM        8'h02
`define ID_OVERCURRENT       8'h10
`define ID_REGEN             8'h30
`define ID_DEVIATION         8'h31
`define ID_VOLTAGE           8'h40
`define ID_OVERSPEED         8'h51
`define ID_OVERLOAD_HI       8'h71
`define ID_OVERLOAD_LO       8'h72
`define ID_HEATSINK          8'ha1
`define ID_ADC_TIMEOUT       8'hb1
`define ID_RUNAWAY           8'hc1
`define ID_ENC_PHASE         8'hc2
`define ID_ENC_AB            8'hc3
`define ID_ENC_Z             8'hc4
`define ID_PHASE_LOSS        8'hf1
`define ID_RESET_MARK        8'h99

`define HIST_DEPTH           4'd10

`endif

//--- tb/fault_chk.sv
// Assertions on the alarm outputs of the servo fault supervisor.
// Assumes a bind to the design top; one pclk domain, presetn active low.
`timescale 1ns/1ps
module fault_chk (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Host side
    input wire       oc_detect,
    input wire       run_enable,
    // Alarm outputs
    input wire       fault_flag_out,
    input wire       fault_code_bit0,
    input wire       fault_code_bit1,
    input wire       fault_code_bit2,
    input wire       power_stage_on,
    input wire [7:0] display_id
);
    // Code bits gathered so one compare covers all three lines
    wire [2:0] code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    wire       alarm = !fault_flag_out;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------------------------------------------------
    // Raising and idle state
    // --------------------------------------------------------------
    AST_OC_RAISE: assert property (fault_flag_out && oc_detect |=> alarm && display_id == 8'h10)
        else $error("overcurrent not raised one cycle after detection");
    AST_IDLE_QUIET: assert property (fault_flag_out |-> code == 3'b000 && display_id == 8'h99)
        else $error("code or id not quiet while no alarm");
    AST_POWER_OFF: assert property (alarm |-> !power_stage_on)
        else $error("power stage on during alarm");
    AST_RESUME: assert property ($rose(fault_flag_out) && run_enable |-> power_stage_on)
        else $error("power stage not resumed on clear with run");
    // --------------------------------------------------------------
    // Code table per identifier
    // --------------------------------------------------------------
    AST_CODE_001: assert property (alarm && display_id == 8'h10 |-> code == 3'b001)
        else $error("overcurrent code wrong");
    AST_CODE_011: assert property (alarm && display_id inside {8'h30, 8'h31} |-> code == 3'b011)
        else $error("regeneration or deviation code wrong");
    AST_CODE_100: assert property (alarm && display_id == 8'h40 |-> code == 3'b100)
        else $error("voltage code wrong");
    AST_CODE_101: assert property (alarm && display_id inside {8'h51, 8'hc1, 8'hc2, 8'hc3, 8'hc4}
                                   |-> code == 3'b101)
        else $error("overspeed or encoder code wrong");
    AST_CODE_111: assert property (alarm && display_id inside {8'h71, 8'h72, 8'ha1} |-> &code)
        else $error("overload or heatsink code wrong");
    AST_CODE_000: assert property (alarm && display_id inside {8'h00, 8'h02, 8'hb1} |-> code == 0)
        else $error("converter, checksum or absolute code wrong");
    AST_CODE_010: assert property (alarm && display_id == 8'hf1 |-> code == 3'b010)
        else $error("missing phase code wrong");
endmodule // fault_chk

bind servo_fault_encoder_history fault_chk u_chk (
    .pclk(pclk), .presetn(presetn), .oc_detect(oc_detect), .run_enable(run_enable),
    .fault_flag_out(fault_flag_out), .fault_code_bit0(fault_code_bit0),
    .fault_code_bit1(fault_code_bit1), .fault_code_bit2(fault_code_bit2),
    .power_stage_on(power_stage_on), .display_id(display_id)
);

//--- tb/host_ctrl_model.sv
// Host motion controller: drives the alarm clear and run command lines.
// Assumes the bench requests clears and runs; changes follow pclk edges.
`timescale 1ns/1ps
module host_ctrl_model (
    // Clock, reset and bench requests
    input  wire pclk,
    input  wire presetn,
    input  wire clr_req,
    input  wire run_req,
    // Supervisor side
    input  wire fault_flag_out,
    output reg  alarm_clear,
    output reg  run_enable
);
    // Clear only while an alarm shows; run stays as commanded, so a clear
    // with run held is a deliberate hazard that a scenario asks for
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_clear <= 1'b0;
            run_enable  <= 1'b0;
        end
        else
        begin
            alarm_clear <= clr_req && !fault_flag_out;
            run_enable  <= run_req;
        end
    end
endmodule // host_ctrl_model

//--- tb/servo_fault_encoder_history_bench.sv
// Self-checking bench for the servo fault supervisor.
// Assumes faults come from vector f, the host model drives clear and run.
`timescale 1ns/1ps
module servo_fault_encoder_history_bench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [16:0] f = 17'h0;
    logic        adc_go = 0, adc_ok = 0, keep = 0, clr_req = 0, run_req = 1, opu = 0, slverr;
    wire  [31:0] prdata;
    wire  [7:0]  display_id;
    wire  [1:0]  display_comm;
    wire         pready, pslverr, fault_flag_out, fault_code_bit0, fault_code_bit1;
    wire         fault_code_bit2, power_stage_on, oc_hold_out, alarm_clear, run_enable;
    wire  [2:0]  code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    int          error_cnt = 0, tests_run = 0;
    logic [7:0]  ids [17] = '{8'h10, 8'h30, 8'h31, 8'h40, 8'h40, 8'h51, 8'h71, 8'h72, 8'ha1,
                              8'hb1, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hf1, 8'h02, 8'h00};
    logic [2:0]  codes [17] = '{3'h1, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h7, 3'h7, 3'h7,
                                3'h0, 3'h5, 3'h5, 3'h5, 3'h5, 3'h2, 3'h0, 3'h0};
    always #2.5 pclk = ~pclk;
    // Short overload limit keeps the inverse-time trip within tens of cycles
    servo_fault_encoder_history #(.OL_LIMIT(32'd1000)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oc_detect(f[0]), .regen_fault(f[1]), .dev_residual(f[2] ? 16'h0401 : 16'h0400),
        .bus_volts(f[3] ? 10'h095 : f[4] ? 10'h1a5 : 10'h1a4),
        .speed_rpm(f[5] ? 13'h1356 : 13'h1355), .load_pct(f[6] ? 8'h88 : f[7] ? 8'h7d : 8'h64),
        .heatsink_hot(f[8]), .adc_start(adc_go), .adc_done(adc_ok), .enc_runaway(f[10]),
        .enc_phase_err(f[11]), .enc_ab_fault(f[12]), .enc_z_fault(f[13]), .phase_loss(f[14]),
        .param_csum_bad(f[15]), .abs_model(1'b1), .position_sense_request(f[16]),
        .abs_data_bad(f[16]), .opu_tx_fail_pwrup(opu), .opu_tx_timeout(opu), .oc_hold_in(keep),
        .alarm_clear(alarm_clear), .run_enable(run_enable), .fault_flag_out(fault_flag_out),
        .fault_code_bit0(fault_code_bit0), .fault_code_bit1(fault_code_bit1),
        .fault_code_bit2(fault_code_bit2), .power_stage_on(power_stage_on),
        .display_id(display_id), .display_comm(display_comm), .oc_hold_out(oc_hold_out));
    host_ctrl_model u_host (.pclk(pclk), .presetn(presetn), .clr_req(clr_req), .run_req(run_req),
        .fault_flag_out(fault_flag_out), .alarm_clear(alarm_clear), .run_enable(run_enable));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Held request until pready is seen high at an edge, data taken there
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("pready", pready, 1'b1);
        q = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task hist(input logic [3:0] i, input logic [7:0] e);
        apb(1'b1, 8'h10, {28'h0, i}, rd);
        apb(1'b0, 8'h14, 32'h0, rd);
        chk("history entry", rd, {24'h0, e});
    endtask
    task count_is(input logic [3:0] e);
        apb(1'b0, 8'h08, 32'h0, rd);
        chk("history count", rd[19:16], e);
    endtask
    task wait_flag(input logic v);
        int n;
        n = 0;
        while (fault_flag_out !== v && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("fault_flag_out", fault_flag_out, v);
    endtask
    task do_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    // Every fault kind raised alone, then cleared with run still held
    task t_table;
        for (int i = 0; i < 17; i++)
        begin
            @(posedge pclk);
            f <= 17'(32'h1 << i);
            adc_go <= (i == 9);
            @(posedge pclk);
            adc_go <= 1'b0;
            wait_flag(1'b0);
            chk("display_id", display_id, ids[i]);
            chk("alarm code", code, codes[i]);
            chk("power_stage_on", power_stage_on, 1'b0);
            hist(4'h0, ids[i]);
            f <= 17'h0;
            clr_req <= 1'b1;
            wait_flag(1'b1);
            clr_req <= 1'b0;
            chk("power_stage_on", power_stage_on, 1'b1);
            hist(4'h1, ids[i]);
            hist(4'h0, 8'h99);
        end
    endtask
    task t_full;
        count_is(4'ha);
        hist(4'h9, ids[12]);
        hist(4'ha, 8'h00);
        apb(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped pslverr", slverr, 1'b1);
        // Done inside the window must keep the converter alarm away
        adc_go <= 1'b1;
        @(posedge pclk);
        adc_go <= 1'b0;
        repeat (1500) @(posedge pclk);
        adc_ok <= 1'b1;
        repeat (1000) @(posedge pclk);
        chk("fault_flag_out", fault_flag_out, 1'b1);
    endtask
    task t_erase;
        apb(1'b1, 8'h00, 32'h0200, rd);
        apb(1'b1, 8'h00, 32'h0202, rd);
        count_is(4'h0);
        opu <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("display_comm", display_comm, 2'b11);
        count_is(4'h0);
        opu <= 1'b0;
    endtask
    task t_power;
        @(posedge pclk);
        f <= 17'h1;
        wait_flag(1'b0);
        keep <= oc_hold_out;
        f <= 17'h0;
        do_reset;
        chk("display_id", display_id, 8'h10);
        apb(1'b1, 8'h00, 32'h1, rd);
        wait_flag(1'b1);
        keep <= 1'b0;
        do_reset;
        chk("fault_flag_out", fault_flag_out, 1'b1);
        hist(4'h0, 8'h99);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        do_reset;
        hist(4'h0, 8'h99);
        t_table;
        t_full;
        t_erase;
        t_power;
        end_sim;
    end
    // Watchdog well past the expected five thousand cycles
    initial
    begin
        #250000;
        error_cnt++;
        end_sim;
    end
endmodule // servo_fault_encoder_history_bench
